/* File: hdl/bpc_top.sv */
// Pin level controller: bus strobes, port 1 alternates, PROM programming, serial
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------------
// Summary of operation
// - Counter 2 inputs need latch one
// - Bit 2 outputs programmable PWM
// - Bit 3 gates address strobe programming
// - Bit 4 gives active-low programming pulse
// - Bit 5 low throughout programming
// - Bit 6 is active-low DMA acknowledge
// - Interrupt 0 low; may request DMA
// - Bit 7 serial printer output
// - Address strobe marks low byte
// - Fetch strobe high unless external code
// - Read strobe low for reads
// - Write strobe low for writes
// - Interrupt 1 input is active low
// - Console uses ASCII asynchronous frames
// - Low pins multiplex address and data
// - Counter 0/1 pins count externally
// - Strobe every eight clocks, skip data access
module bpc_top
  import bpc_pkg::*;
#(
  parameter int unsigned PULSE_CNT = PULSE_CYCLES,
  parameter int unsigned BIT_CNT   = BIT_CYCLES
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  // Reset pin, high active
  input  wire logic        I_RESET_PIN,
  // Core bus requests
  input  wire logic        I_RD_REQ,
  input  wire logic        I_WR_REQ,
  input  wire logic        I_FETCH_REQ,
  input  wire logic        I_EXT_CODE,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  output logic [7:0]       O_RDATA,
  output logic             O_RDATA_VLD,
  // External bus pins
  input  wire logic [7:0]  I_LOW_ADDR_DATA_BUS,
  output logic [7:0]       O_LOW_ADDR_DATA_BUS,
  output logic             O_LOW_ADDR_DATA_BUS_OE,
  output logic [7:0]       O_HIGH_ADDR_BUS,
  output logic             O_ADDR_LATCH_STROBE,
  output logic             O_PROGRAM_FETCH_STROBE_N,
  output logic             O_RD_N,
  output logic             O_WR_N,
  // Port 1 latch and alternate control
  input  wire logic [7:0]  I_PORT1_LATCH,
  input  wire logic [7:0]  I_PORT1_PIN,
  input  wire logic        I_PWM_EN,
  input  wire logic [15:0] I_PWM_HIGH,
  input  wire logic [15:0] I_PWM_LOW,
  input  wire logic        I_WRITE_PROM_COMMAND_START,
  input  wire logic [15:0] I_PULSE_WIDTH,
  input  wire logic        I_DMA_EN,
  input  wire logic        I_LP_START,
  input  wire logic [7:0]  I_LP_DATA,
  output logic [7:0]       O_PORT1,
  output logic             O_WRITE_PROM_COMMAND_BUSY,
  output logic             O_LP_BUSY,
  // Interrupt and counter pins
  input  wire logic        I_EXT_IRQ0_DMA_REQUEST_N,
  input  wire logic        I_EXT_IRQ1_N,
  input  wire logic        I_COUNTER0_INPUT,
  input  wire logic        I_COUNTER1_INPUT,
  input  wire logic [1:0]  I_CNT_EXT_SEL,
  output logic             O_IRQ0,
  output logic             O_IRQ1,
  output logic [2:0]       O_CNT_TICK,
  output logic             O_CNT2_CAPTURE,
  // Console link
  input  wire logic        I_CON_START,
  input  wire logic [7:0]  I_CON_DATA,
  output logic             O_CON_BUSY,
  output logic             O_CON_TXD
);
  // ----------------------------------------------------------------
  // Reset release and reset pin filter
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  typedef struct packed {
    logic [4:0]  rcnt;
    logic        pin_rst;
    logic [2:0]  phase;
    bpc_bus_e    bus;
    logic [7:0]  rdata;
    logic        rvld;
    logic [7:0]  lad;
    logic        lad_oe;
    logic [7:0]  had;
    logic        ale;
    logic        program_fetch_strobe_n;
    logic        rd_n;
    logic        wr_n;
    bpc_write_prom_command_e   write_prom_command;
    logic [15:0] pcnt;
    logic        gate;
    logic        pulse_n;
    logic        vpp_n;
    logic [15:0] pwm_cnt;
    logic        pwm;
    logic [4:0]  pin_prev;
    logic        irq0;
    logic        irq1;
    logic [2:0]  tick;
    logic        cap2;
    logic        pbusy;
  } bpc_st_s;
  bpc_st_s s_q;
  bpc_st_s s_d;
  logic    lp_busy;
  logic    lp_txd;
  logic    con_busy;
  logic    con_txd;
  logic    dma_ack_n;

  assign dma_ack_n = ~(I_DMA_EN & ~I_EXT_IRQ0_DMA_REQUEST_N);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.rvld = 1'b0;
    s_d.tick = 3'b000;
    s_d.cap2 = 1'b0;
    // Reset pin must stand high two machine cycles
    if (I_RESET_PIN) begin
      if (s_q.rcnt != 5'(RESET_MCYCLES * OSC_PER_MCYCLE)) begin
        s_d.rcnt = s_q.rcnt + 5'h01;
      end
    end else begin
      s_d.rcnt = 5'h00;
    end
    s_d.pin_rst = (s_d.rcnt == 5'(RESET_MCYCLES * OSC_PER_MCYCLE));
    // Strobe rhythm, one pulse per eight clocks
    s_d.phase = s_q.phase + 3'h1;
    s_d.ale   = 1'b0;
    s_d.program_fetch_strobe_n = 1'b1;
    s_d.rd_n   = 1'b1;
    s_d.wr_n   = 1'b1;
    case (s_q.bus)
      BPC_IDLE: begin
        s_d.lad_oe = 1'b0;
        if (s_q.phase == 3'h7 && !s_q.pin_rst) begin
          if (I_RD_REQ || I_WR_REQ || (I_FETCH_REQ && I_EXT_CODE)) begin
            s_d.bus    = BPC_ADDR;
            s_d.lad    = I_ADDR[7:0];
            s_d.lad_oe = 1'b1;
            s_d.had    = I_ADDR[15:8];
          end
        end
      end
      BPC_ADDR: begin
        if (s_q.phase == 3'h1) begin
          s_d.lad_oe = I_WR_REQ;
          s_d.lad    = I_WDATA;
          if (I_WR_REQ) begin
            s_d.bus = BPC_WR;
          end else if (I_RD_REQ) begin
            s_d.bus = BPC_RD;
          end else begin
            s_d.bus = BPC_FETCH;
          end
        end
      end
      BPC_RD: begin
        s_d.rd_n = (s_q.phase == 3'h7) ? 1'b1 : 1'b0;
        if (s_q.phase == 3'h7) begin
          s_d.rdata = I_LOW_ADDR_DATA_BUS;
          s_d.rvld  = 1'b1;
          s_d.bus   = BPC_IDLE;
        end
      end
      BPC_WR: begin
        s_d.wr_n = (s_q.phase == 3'h7) ? 1'b1 : 1'b0;
        if (s_q.phase == 3'h7) begin
          s_d.bus = BPC_IDLE;
        end
      end
      BPC_FETCH: begin
        s_d.program_fetch_strobe_n = ~(I_EXT_CODE & (s_q.phase != 3'h7));
        if (s_q.phase == 3'h7) begin
          s_d.rdata = I_LOW_ADDR_DATA_BUS;
          s_d.rvld  = 1'b1;
          s_d.bus   = BPC_IDLE;
        end
      end
      default: begin
        s_d.bus = BPC_IDLE;
      end
    endcase
    // Strobe marks every slot while the gate is high, but not the one that closes a data access
    if (s_q.phase == 3'h7) begin
      s_d.ale = s_q.gate & (s_q.bus != BPC_RD) & (s_q.bus != BPC_WR);
    end
    // Programming sequence
    case (s_q.write_prom_command)
      BPC_P_OFF: begin
        s_d.gate    = 1'b1;
        s_d.vpp_n   = 1'b1;
        s_d.pulse_n = 1'b1;
        if (I_WRITE_PROM_COMMAND_START) begin
          s_d.write_prom_command  = BPC_P_SETUP;
          s_d.gate  = 1'b0;
          s_d.vpp_n = 1'b0;
          s_d.pcnt  = 16'(GUARD_CYCLES);
        end
      end
      BPC_P_SETUP: begin
        s_d.pcnt = s_q.pcnt - 16'h0001;
        if (s_q.pcnt == 16'h0001) begin
          s_d.write_prom_command    = BPC_P_PULSE;
          s_d.pulse_n = 1'b0;
          s_d.pcnt    = (I_PULSE_WIDTH != 16'h0000) ? I_PULSE_WIDTH : 16'(PULSE_CNT);
        end
      end
      BPC_P_PULSE: begin
        s_d.pcnt = s_q.pcnt - 16'h0001;
        if (s_q.pcnt == 16'h0001) begin
          s_d.write_prom_command    = BPC_P_HOLD;
          s_d.pulse_n = 1'b1;
          s_d.pcnt    = 16'(GUARD_CYCLES);
        end
      end
      BPC_P_HOLD: begin
        s_d.pcnt = s_q.pcnt - 16'h0001;
        if (s_q.pcnt == 16'h0001) begin
          s_d.write_prom_command = BPC_P_OFF;
        end
      end
      default: begin
        s_d.write_prom_command = BPC_P_OFF;
      end
    endcase
    // Pulse width modulation
    if (!I_PWM_EN) begin
      s_d.pwm     = 1'b1;
      s_d.pwm_cnt = 16'h0000;
    end else if (s_q.pwm_cnt == 16'h0000) begin
      s_d.pwm     = ~s_q.pwm;
      s_d.pwm_cnt = s_q.pwm ? I_PWM_LOW : I_PWM_HIGH;
    end else begin
      s_d.pwm_cnt = s_q.pwm_cnt - 16'h0001;
    end
    // Interrupt and counter inputs
    s_d.pin_prev = {I_PORT1_PIN[1:0], I_COUNTER1_INPUT, I_COUNTER0_INPUT,
                    I_EXT_IRQ1_N};
    s_d.irq0 = ~I_EXT_IRQ0_DMA_REQUEST_N & ~I_DMA_EN;
    s_d.irq1 = ~I_EXT_IRQ1_N;
    s_d.tick[0] = I_CNT_EXT_SEL[0] & fall(s_q.pin_prev[1], I_COUNTER0_INPUT);
    s_d.tick[1] = I_CNT_EXT_SEL[1] & fall(s_q.pin_prev[2], I_COUNTER1_INPUT);
    s_d.tick[2] = I_PORT1_LATCH[0] & fall(s_q.pin_prev[3], I_PORT1_PIN[0]);
    s_d.cap2    = I_PORT1_LATCH[1] & fall(s_q.pin_prev[4], I_PORT1_PIN[1]);
    // Pin reset ends a pulse before the enable is let go
    if (s_q.pin_rst) begin
      s_d.bus     = BPC_IDLE;
      s_d.pulse_n = 1'b1;
      if (s_q.write_prom_command == BPC_P_OFF) begin
        s_d.write_prom_command  = BPC_P_OFF;
        s_d.gate  = 1'b1;
        s_d.vpp_n = 1'b1;
      end else if (s_q.write_prom_command != BPC_P_HOLD) begin
        s_d.write_prom_command = BPC_P_HOLD;
        s_d.pcnt = 16'(GUARD_CYCLES);
      end
    end
    s_d.pbusy = (s_d.write_prom_command != BPC_P_OFF);
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{rcnt: 5'h00, pin_rst: 1'b0, phase: 3'h0, bus: BPC_IDLE,
               rdata: 8'h00, rvld: 1'b0, lad: 8'h00, lad_oe: 1'b0, had: 8'h00,
               ale: 1'b0, program_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, write_prom_command: BPC_P_OFF,
               pcnt: 16'h0000, gate: 1'b1, pulse_n: 1'b1, vpp_n: 1'b1,
               pwm_cnt: 16'h0000, pwm: 1'b1, pin_prev: 5'h1f, irq0: 1'b0,
               irq1: 1'b0, tick: 3'b000, cap2: 1'b0, pbusy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial ports
  // ----------------------------------------------------------------
  bpc_ser_tx #(.BIT_CNT(BIT_CNT)) u_lp (
    .clk   (I_CLK),
    .rst_n (rst_n),
    .start (I_LP_START),
    .data  (I_LP_DATA),
    .busy  (lp_busy),
    .txd   (lp_txd)
  );
  bpc_ser_tx #(.BIT_CNT(BIT_CNT)) u_con (
    .clk   (I_CLK),
    .rst_n (rst_n),
    .start (I_CON_START),
    .data  (I_CON_DATA),
    .busy  (con_busy),
    .txd   (con_txd)
  );

  // ----------------------------------------------------------------
  // Port 1 pin register
  // ----------------------------------------------------------------
  logic [7:0] port1_q;
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      port1_q <= PORT1_RST;
    end else begin
      port1_q[1:0] <= I_PORT1_LATCH[1:0];
      port1_q[2]   <= I_PWM_EN ? s_d.pwm : I_PORT1_LATCH[2];
      port1_q[3]   <= s_d.gate;
      port1_q[4]   <= s_d.pulse_n;
      port1_q[5]   <= s_d.vpp_n;
      port1_q[6]   <= I_DMA_EN ? dma_ack_n : I_PORT1_LATCH[6];
      port1_q[7]   <= lp_txd;
    end
  end

  assign O_PORT1                  = port1_q;
  assign O_LOW_ADDR_DATA_BUS      = s_q.lad;
  assign O_LOW_ADDR_DATA_BUS_OE   = s_q.lad_oe;
  assign O_HIGH_ADDR_BUS          = s_q.had;
  assign O_ADDR_LATCH_STROBE      = s_q.ale;
  assign O_PROGRAM_FETCH_STROBE_N = s_q.program_fetch_strobe_n;
  assign O_RD_N                   = s_q.rd_n;
  assign O_WR_N                   = s_q.wr_n;
  assign O_RDATA                  = s_q.rdata;
  assign O_RDATA_VLD              = s_q.rvld;
  assign O_WRITE_PROM_COMMAND_BUSY              = s_q.pbusy;
  assign O_LP_BUSY                = lp_busy;
  assign O_CON_BUSY               = con_busy;
  assign O_CON_TXD                = con_txd;
  assign O_IRQ0                   = s_q.irq0;
  assign O_IRQ1                   = s_q.irq1;
  assign O_CNT_TICK               = s_q.tick;
  assign O_CNT2_CAPTURE           = s_q.cap2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence pulse_begin_s;
    $fell(port1_q[4]);
  endsequence
  sequence enable_low_s;
    !port1_q[5];
  endsequence
  pulse_window_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    pulse_begin_s |-> enable_low_s) else $error("pulse outside enable");
  pulse_release_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    $rose(port1_q[5]) |-> $past(port1_q[4], 2)) else $error("enable dropped early");
  gate_write_prom_command_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    !port1_q[5] |-> !port1_q[3]) else $error("strobe not gated");
  vpp_hold_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_WRITE_PROM_COMMAND_BUSY && s_q.write_prom_command != BPC_P_HOLD |-> !port1_q[5]) else $error("enable lost");
  ale_rate_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_ADDR_LATCH_STROBE |=> !O_ADDR_LATCH_STROBE [*7]) else $error("strobe too fast");
  fetch_idle_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    !O_PROGRAM_FETCH_STROBE_N |-> $past(I_EXT_CODE)) else $error("fetch without code");
  rd_wr_excl_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    !(O_RD_N == 1'b0 && O_WR_N == 1'b0)) else $error("read and write together");
  rd_len_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    $fell(O_RD_N) |-> !O_RD_N [*5] ##1 O_RD_N) else $error("read strobe length");
  ale_skip_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    $rose(O_RD_N) || $rose(O_WR_N) |-> !O_ADDR_LATCH_STROBE) else $error("no skip");
  dma_ack_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    I_DMA_EN && !I_EXT_IRQ0_DMA_REQUEST_N |=> !port1_q[6]) else $error("no acknowledge");
  irq1_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
    !I_EXT_IRQ1_N |=> O_IRQ1) else $error("irq1 missed");
endmodule
`default_nettype wire

/* File: hdl/bpc_pkg.sv */
// Package of constants and types for the pin and PROM programming controller
package bpc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned OSC_PER_MCYCLE  = 12;
  localparam int unsigned OSC_PER_STROBE  = 8;
  localparam int unsigned RESET_MCYCLES   = 2;
  localparam int unsigned BAUD_DEFAULT    = 9600;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned PULSE_US_DEFAULT = 50;
  localparam int unsigned PULSE_CYCLES    = (PULSE_US_DEFAULT * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned GUARD_CYCLES    = 4;
  localparam int unsigned CHAR_BITS       = 8;
  localparam int unsigned FRAME_BITS      = CHAR_BITS + 2;
  // ----------------------------------------------------------------
  // Reset values of pin latches
  // ----------------------------------------------------------------
  localparam logic [7:0]  PORT1_RST       = 8'hff;
  // ----------------------------------------------------------------
  // Bus cycle states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BPC_IDLE  = 5'h01,
    BPC_ADDR  = 5'h02,
    BPC_RD    = 5'h04,
    BPC_WR    = 5'h08,
    BPC_FETCH = 5'h10
  } bpc_bus_e;
  // Programming sequence states
  typedef enum logic [3:0] {
    BPC_P_OFF   = 4'h1,
    BPC_P_SETUP = 4'h2,
    BPC_P_PULSE = 4'h4,
    BPC_P_HOLD  = 4'h8
  } bpc_write_prom_command_e;
endpackage

/* File: hdl/bpc_ser_tx.sv */
// Asynchronous serial transmitter, 8N1, used for console and printer
`timescale 1ns/1ps
`default_nettype none
module bpc_ser_tx
  import bpc_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Character in
  input  wire logic       start,
  input  wire logic [7:0] data,
  // Line out
  output logic            busy,
  output logic            txd
);
  typedef struct packed {
    logic [15:0] div;
    logic [3:0]  bitn;
    logic [9:0]  sh;
    logic        busy;
  } bpc_tx_s;
  bpc_tx_s s_q;
  bpc_tx_s s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (start) begin
        s_d.sh   = {1'b1, data, 1'b0};
        s_d.busy = 1'b1;
        s_d.bitn = 4'h0;
        s_d.div  = 16'h0000;
      end
    end else if (s_d.div == 16'(BIT_CNT - 1)) begin
      s_d.div = 16'h0000;
      s_d.sh  = {1'b1, s_q.sh[9:1]};
      if (s_q.bitn == 4'(FRAME_BITS - 1)) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.bitn = s_q.bitn + 4'h1;
      end
    end else begin
      s_d.div = s_q.div + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{div: 16'h0000, bitn: 4'h0, sh: 10'h3ff, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign txd  = s_q.sh[0];
endmodule
`default_nettype wire

/* File: sim/bpc_partner.sv */
// Model of the external memory on the multiplexed low bus
`timescale 1ns/1ps
`default_nettype none
module bpc_partner (
  // Strobes and high address
  input  wire logic       i_rd_n,
  input  wire logic       i_program_fetch_strobe_n,
  input  wire logic [7:0] i_high,
  // Address strobe and its gate from port 1
  input  wire logic       i_ale,
  input  wire logic       i_gate,
  // Low bus as driven by the controller
  input  wire logic [7:0] i_dut_out,
  input  wire logic       i_dut_oe,
  // Resolved low bus level
  output logic [7:0]      o_bus
);
  logic [7:0] last_q = 8'h00;
  logic [7:0] lat_q  = 8'h00;
  logic [7:0] drv;
  logic       ale_g;
  // External latch sees the strobe through an AND with the gate pin
  assign ale_g = i_ale & i_gate;
  // Low address byte is held as the gated strobe falls
  always @(negedge ale_g) begin
    lat_q = o_bus;
  end
  // Released bus shows the inverse of the last value
  always @(posedge i_rd_n or posedge i_program_fetch_strobe_n) begin
    last_q = i_high ^ lat_q ^ 8'h3c;
  end
  always_comb begin
    if (!i_rd_n || !i_program_fetch_strobe_n) begin
      drv = i_high ^ lat_q ^ 8'h3c;
    end else begin
      drv = ~last_q;
    end
  end
  assign o_bus = i_dut_oe ? i_dut_out : drv;
endmodule
`default_nettype wire

/* File: sim/bpc_top_tb.sv */
// Self-checking bench for the pin and PROM programming controller
`timescale 1ns/1ps
`default_nettype none
module bpc_top_tb;
  import bpc_pkg::*;
  localparam int unsigned BITS = 4;
  localparam int unsigned PW   = 8;
  localparam int unsigned STROBE = 5;
  logic        clk = 1'b0, nrst = 1'b0, rst_pin = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, fe = 1'b0, ext = 1'b0;
  logic [15:0] addr = 16'h0000, pw = 16'h0000, pwm_hi = 16'h0000, pwm_lo = 16'h0000;
  logic [7:0]  wdat = 8'h00, latch = 8'hff, pin = 8'hff, lpd = 8'h00, cd = 8'h00;
  logic        pwm_en = 1'b0, ps = 1'b0, dma_en = 1'b0, lps = 1'b0, cs = 1'b0;
  logic        irq0_n = 1'b1, irq1_n = 1'b1, c0 = 1'b1, c1 = 1'b1;
  logic [1:0]  sel = 2'b00;
  logic [7:0]  rdata, bus_in, bus_out, hi, p1;
  logic        vld, oe, ale, program_fetch_strobe_n, rd_n, wr_n, pbusy, lpbusy;
  logic        irq0, irq1, cap, cbusy, txd;
  logic [2:0]  tick;
  int          errors = 0, total_checks = 0, cycles = 0;

  always #50 clk = ~clk;

  bpc_top #(.PULSE_CNT(PW), .BIT_CNT(BITS)) i_dut (
    .I_CLK(clk), .I_NRST(nrst), .I_RESET_PIN(rst_pin), .I_RD_REQ(rd), .I_WR_REQ(wr),
    .I_FETCH_REQ(fe), .I_EXT_CODE(ext), .I_ADDR(addr), .I_WDATA(wdat), .O_RDATA(rdata),
    .O_RDATA_VLD(vld), .I_LOW_ADDR_DATA_BUS(bus_in), .O_LOW_ADDR_DATA_BUS(bus_out),
    .O_LOW_ADDR_DATA_BUS_OE(oe), .O_HIGH_ADDR_BUS(hi), .O_ADDR_LATCH_STROBE(ale),
    .O_PROGRAM_FETCH_STROBE_N(program_fetch_strobe_n), .O_RD_N(rd_n), .O_WR_N(wr_n),
    .I_PORT1_LATCH(latch), .I_PORT1_PIN(pin), .I_PWM_EN(pwm_en), .I_PWM_HIGH(pwm_hi),
    .I_PWM_LOW(pwm_lo), .I_WRITE_PROM_COMMAND_START(ps), .I_PULSE_WIDTH(pw), .I_DMA_EN(dma_en),
    .I_LP_START(lps), .I_LP_DATA(lpd), .O_PORT1(p1), .O_WRITE_PROM_COMMAND_BUSY(pbusy),
    .O_LP_BUSY(lpbusy), .I_EXT_IRQ0_DMA_REQUEST_N(irq0_n), .I_EXT_IRQ1_N(irq1_n),
    .I_COUNTER0_INPUT(c0), .I_COUNTER1_INPUT(c1), .I_CNT_EXT_SEL(sel), .O_IRQ0(irq0),
    .O_IRQ1(irq1), .O_CNT_TICK(tick), .O_CNT2_CAPTURE(cap), .I_CON_START(cs),
    .I_CON_DATA(cd), .O_CON_BUSY(cbusy), .O_CON_TXD(txd));

  bpc_partner i_mem (.i_rd_n(rd_n), .i_program_fetch_strobe_n(program_fetch_strobe_n), .i_high(hi),
    .i_ale(ale), .i_gate(p1[3]),
    .i_dut_out(bus_out), .i_dut_oe(oe), .o_bus(bus_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic bus_op(input int kind, input logic [15:0] a, input logic [7:0] d);
    int   lo, al, hit, wd, gv;
    logic st;
    lo = 0; al = 0; hit = 0; wd = 0; gv = 0;
    addr = a; wdat = d;
    rd = (kind == 0); wr = (kind == 1); fe = (kind == 2);
    repeat (32) begin
      cyc(1);
      st = (kind == 0) ? rd_n : (kind == 1) ? wr_n : program_fetch_strobe_n;
      al += ale;
      if (st === 1'b0) begin
        lo++;
        hit += (hi === a[15:8]);
        wd += (oe === 1'b1 && bus_out === d);
      end
      if (kind == 0 && vld === 1'b1) begin
        gv++;
        check(rdata, a[15:8] ^ a[7:0] ^ 8'h3c, "read data");
      end
      if (vld === 1'b1 || (kind == 1 && lo > 0 && st === 1'b1)) begin
        rd = 1'b0; wr = 1'b0; fe = 1'b0;
      end
    end
    cyc(1);
    rd = 1'b0; wr = 1'b0; fe = 1'b0;
    cyc(1);
    check(lo, (kind == 2 && !ext) ? 0 : STROBE, "strobe width");
    check(hit, lo, "high address");
    if (kind == 1) check(wd, lo, "write data");
    if (kind == 0) check(gv, 1, "read answer");
    check(al, (kind == 2) ? 4 : 3, "latch strobe count");
    $display("Test bus kind %0d done", kind);
  endtask

  task automatic write_prom_command_test;
    int lo, vlo, g, bad;
    lo = 0; vlo = 0; g = 0; bad = 0;
    pw = 16'h0000; ps = 1'b1; cyc(1); ps = 1'b0;
    repeat (40) begin
      cyc(1);
      ps = (lo == 3); // a start while busy must be ignored
      lo += !p1[4]; vlo += !p1[5]; g += !p1[3];
      if ((!p1[4] && p1[5]) || (!p1[5] && p1[3] && ale)) bad++;
    end
    check(lo, PW, "pulse width");
    check(vlo > lo, 1'b1, "enable window");
    check(g > 0, 1'b1, "strobe gate");
    check(bad, 0, "pulse and gated strobe");
    check(p1[5:3], 3'b111, "idle after programming");
    cyc(1);
    pw = 16'd200; ps = 1'b1; cyc(1); ps = 1'b0;
    rst_pin = 1'b1; cyc(10); rst_pin = 1'b0; cyc(2);
    check(pbusy, 1'b1, "short reset pin");
    rst_pin = 1'b1; cyc(30); rst_pin = 1'b0; cyc(2);
    check({pbusy, p1[5]}, 2'b01, "reset pin");
    $display("Test programming done");
  endtask

  task automatic irq_test;
    dma_en = 1'b1; irq0_n = 1'b0; cyc(2);
    check({p1[6], irq0}, 2'b00, "dma ack");
    irq0_n = 1'b1; cyc(2);
    check(p1[6], 1'b1, "dma ack release");
    dma_en = 1'b0; irq0_n = 1'b0; irq1_n = 1'b0; cyc(3);
    check({p1[6], irq0, irq1}, 3'b111, "interrupt low");
    irq0_n = 1'b1; irq1_n = 1'b1; cyc(3);
    check({irq0, irq1}, 2'b00, "interrupt idle");
    $display("Test interrupts done");
  endtask

  task automatic ser_test(input logic con, input logic [7:0] d);
    logic [9:0] fr;
    int         n;
    fr = {1'b1, d, 1'b0};
    n = 0;
    if (con) begin
      cd = d; cs = 1'b1;
    end else begin
      lpd = d; lps = 1'b1;
    end
    cyc(1);
    cs = 1'b0; lps = 1'b0;
    check(con ? cbusy : lpbusy, 1'b1, "serial busy");
    while ((con ? txd : p1[7]) !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    cyc(BITS / 2);
    for (int i = 0; i < 10; i++) begin
      check(con ? txd : p1[7], fr[i], "serial bit");
      cyc(BITS);
    end
    $display("Test serial %0d done", con);
  endtask

  task automatic cnt_test(input int s, input logic [7:0] lat, input int exp);
    int n;
    n = 0;
    cyc(1);
    latch = lat; sel = 2'b11;
    cyc(2);
    case (s)
      0: c0 = 1'b0;
      1: c1 = 1'b0;
      default: pin[s-2] = 1'b0;
    endcase
    repeat (6) begin
      cyc(1);
      n += (s < 3) ? tick[s] : cap;
    end
    c0 = 1'b1; c1 = 1'b1; pin = 8'hff; latch = 8'hff;
    check(n, exp, "count edge");
    $display("Test counter %0d done", s);
  endtask

  task automatic pwm_test;
    int h, l, n;
    h = 0; l = 0; n = 0;
    pwm_hi = 16'h0003; pwm_lo = 16'h0005; pwm_en = 1'b1;
    cyc(20);
    while (p1[2] !== 1'b0 && n < 30) begin cyc(1); n++; end
    while (p1[2] !== 1'b1 && n < 30) begin cyc(1); n++; end
    while (p1[2] === 1'b1 && h < 30) begin cyc(1); h++; end
    while (p1[2] === 1'b0 && l < 30) begin cyc(1); l++; end
    pwm_en = 1'b0;
    check(h, 4, "pwm high");
    check(l, 6, "pwm low");
    $display("Test pwm done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(3);
    check({program_fetch_strobe_n, rd_n, wr_n, oe, p1}, {4'b1110, 8'hff}, "reset values");
    bus_op(0, 16'h12a7, 8'h00);
    bus_op(0, 16'hffff, 8'h00);
    bus_op(1, 16'h3456, 8'h5a);
    bus_op(2, 16'h0100, 8'h00);
    ext = 1'b1;
    bus_op(2, 16'h0200, 8'h00);
    ext = 1'b0;
    write_prom_command_test;
    irq_test;
    ser_test(1'b0, 8'ha5);
    ser_test(1'b1, 8'h0d);
    cnt_test(0, 8'hff, 1);
    cnt_test(1, 8'hff, 1);
    cnt_test(2, 8'hff, 1);
    cnt_test(3, 8'hff, 1);
    cnt_test(2, 8'hfe, 0);
    cnt_test(3, 8'hfd, 0);
    pwm_test;
    give_verdict;
  end
endmodule
`default_nettype wire
